//--- common/pgc_defines.svh
`ifndef PGC_DEFINES_SVH
`define PGC_DEFINES_SVH

// register indices on the management interface
`define PGC_LPNP_ADDR       5'h08
`define PGC_GCTL_ADDR       5'h09

// link-partner next page layout
`define PGC_LPNP_NP_BIT     15
`define PGC_LPNP_ACK_BIT    14
`define PGC_LPNP_MP_BIT     13
`define PGC_LPNP_ACK2_BIT   12
`define PGC_LPNP_TOG_BIT    11
`define PGC_LPNP_MSG_HI     10
`define PGC_LPNP_RESET      16'h0000

// gigabit control layout
`define PGC_GCTL_TM_HI      15
`define PGC_GCTL_TM_LO      13
`define PGC_GCTL_MSEN_BIT   12
`define PGC_GCTL_MSVAL_BIT  11
`define PGC_GCTL_PTYPE_BIT  10
`define PGC_GCTL_FD_BIT     9
`define PGC_GCTL_HD_BIT     8
`define PGC_GCTL_RESET      16'h0700
`define PGC_GCTL_RSVD_VALUE 8'h00

`endif

//--- common/pgc_pkg.sv
package pgc_pkg;

	typedef enum logic [2:0] {
		PGC_TM_NORMAL,
		PGC_TM_WAVEFORM,
		PGC_TM_JITTER_MASTER,
		PGC_TM_JITTER_SLAVE,
		PGC_TM_DISTORTION,
		PGC_TM_RSVD5,
		PGC_TM_RSVD6,
		PGC_TM_RSVD7
	} pgc_test_mode_t;

	typedef struct packed {
		logic [15:0] lp_next_page;
		logic [15:0] gig_ctrl;
		logic [15:0] rd_data;
	} pgc_state_t;

endpackage

//--- core/pgc_regs.sv
`timescale 1ns/1ns
// Contract
// - bit 15 of partner page reads 1 when more pages follow, else 0.
// - bit 14 read-only, reports partner acknowledge of link word.
// - bit 13 read-only message/unformatted flag; bits 10:0 message field.
// - bit 12 read-only, partner able to act on information.
// - bit 11 read-only toggle as received from partner.
// - control bits 15:13 select test mode, reset 000, 101-111 reserved.
// - selected test mode drives test waveform on all 4 pairs, no partner.
// - control bit 12 enables manual master/slave, reset 0.
// - control bit 11 forces master or slave, ignored unless manual.
// - control bit 10 port type preference, reset 1, used only if automatic.
// - control bit 9 advertises 1000BASE-T full duplex, reset 1.
// - control bit 8 advertises 1000BASE-T half duplex, reset 1.
`include "pgc_defines.svh"

module pgc_regs
	import pgc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// management register port, same clock domain
	input  wire logic [4:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	// received next page from the negotiation engine
	input  wire logic        np_rx_valid_i,
	input  wire logic [15:0] np_rx_word_i,
	// control outputs to the transmitter and negotiation engine
	output logic      [2:0]  test_mode_o,
	output logic             test_active_o,
	output logic      [3:0]  test_pair_en_o,
	output logic             ms_manual_o,
	output logic             ms_force_master_o,
	output logic             ms_prefer_master_o,
	output logic             adv_1000_fd_o,
	output logic             adv_1000_hd_o
);

////////////////////////////////////////////////////////////////////////////////

	// reserved low byte of the control word, fixed whatever the host writes
	localparam logic [7:0] RSVD_LOW = `PGC_GCTL_RSVD_VALUE;

	pgc_state_t     st;
	pgc_state_t     next_st;
	pgc_test_mode_t tm;
	logic           hit_np;
	logic           hit_ctrl;
	logic           wr_ctrl;
	logic           rd_np;
	logic           rd_ctrl;
	logic [15:0]    ctrl_wr_val;
	logic [15:0]    rd_mux;
	logic           test_on;
	logic           cfg_manual;
	logic           cfg_value;
	logic           cfg_ptype;

////////////////////////////////////////////////////////////////////////////////

	// single-cycle strobes; index and data stand across the sampling edge
	assign hit_np   = (reg_addr_i == `PGC_LPNP_ADDR);
	assign hit_ctrl = (reg_addr_i == `PGC_GCTL_ADDR);
	assign wr_ctrl  = reg_wr_i & hit_ctrl;
	assign rd_np    = reg_rd_i & hit_np;
	assign rd_ctrl  = reg_rd_i & hit_ctrl;

	// the partner register is read-only to the host: a write there has no
	// decode term at all and is dropped

	// per-bit merge of the host word; bits below the half-duplex field are
	// reserved and keep their fixed value so software cannot park data there
	for (genvar b = 0; b < 16; b++) begin : g_ctrl_bit
		if (b >= `PGC_GCTL_HD_BIT) begin : g_rw
			assign ctrl_wr_val[b] = reg_wdata_i[b];
		end else begin : g_rsvd
			assign ctrl_wr_val[b] = RSVD_LOW[b];
		end
	end

	// unmapped indices read as zero rather than a stale word
	always_comb begin
		rd_mux = 16'h0000;
		if (rd_np) begin
			rd_mux = st.lp_next_page;
		end else if (rd_ctrl) begin
			rd_mux = st.gig_ctrl;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_st = st;
		// whole code word latched each page, no per-bit processing
		if (np_rx_valid_i) begin
			next_st.lp_next_page[`PGC_LPNP_NP_BIT] =
				np_rx_word_i[`PGC_LPNP_NP_BIT];
			next_st.lp_next_page[`PGC_LPNP_ACK_BIT] =
				np_rx_word_i[`PGC_LPNP_ACK_BIT];
			next_st.lp_next_page[`PGC_LPNP_MP_BIT] =
				np_rx_word_i[`PGC_LPNP_MP_BIT];
			next_st.lp_next_page[`PGC_LPNP_ACK2_BIT] =
				np_rx_word_i[`PGC_LPNP_ACK2_BIT];
			next_st.lp_next_page[`PGC_LPNP_TOG_BIT] =
				np_rx_word_i[`PGC_LPNP_TOG_BIT];
			next_st.lp_next_page[`PGC_LPNP_MSG_HI:0] =
				np_rx_word_i[`PGC_LPNP_MSG_HI:0];
		end
		if (wr_ctrl) begin
			next_st.gig_ctrl = ctrl_wr_val;
		end
		// registered read data holds until the next read strobe, so a slow
		// host may take it at leisure
		if (reg_rd_i) begin
			next_st.rd_data = rd_mux;
		end
	end

	// asynchronous clear lands the advertised defaults before any clock
	// runs, so a link cannot come up on stale settings
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st.lp_next_page <= `PGC_LPNP_RESET;
			st.gig_ctrl     <= `PGC_GCTL_RESET;
			st.rd_data      <= 16'h0000;
		end else begin
			st <= next_st;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	assign reg_rdata_o = st.rd_data;
	assign test_mode_o = st.gig_ctrl[`PGC_GCTL_TM_HI:`PGC_GCTL_TM_LO];
	assign tm          = pgc_test_mode_t'(test_mode_o);

	// reserved codes behave as normal operation; the speed and negotiation
	// preconditions are software's duty and are not checked here
	always_comb begin
		case (tm)
			PGC_TM_NORMAL: begin
				test_on = 1'h0;
			end
			PGC_TM_WAVEFORM: begin
				test_on = 1'h1;
			end
			PGC_TM_JITTER_MASTER: begin
				test_on = 1'h1;
			end
			PGC_TM_JITTER_SLAVE: begin
				test_on = 1'h1;
			end
			PGC_TM_DISTORTION: begin
				test_on = 1'h1;
			end
			PGC_TM_RSVD5: begin
				test_on = 1'h0;
			end
			PGC_TM_RSVD6: begin
				test_on = 1'h0;
			end
			PGC_TM_RSVD7: begin
				test_on = 1'h0;
			end
			default: begin
				test_on = 1'h0;
			end
		endcase
	end

	assign test_active_o = test_on;

	// every pair carries the pattern; no partner handshake gates it
	for (genvar p = 0; p < 4; p++) begin : g_pair
		assign test_pair_en_o[p] = test_on;
	end

////////////////////////////////////////////////////////////////////////////////

	assign cfg_manual = st.gig_ctrl[`PGC_GCTL_MSEN_BIT];
	assign cfg_value  = st.gig_ctrl[`PGC_GCTL_MSVAL_BIT];
	assign cfg_ptype  = st.gig_ctrl[`PGC_GCTL_PTYPE_BIT];

	assign ms_manual_o = cfg_manual;

	// the forced value only counts with manual set, the port type only
	// without it, so the negotiation engine never sees both at once
	always_comb begin
		case ({cfg_manual, cfg_value})
			2'h0: begin
				ms_force_master_o  = 1'h0;
				ms_prefer_master_o = cfg_ptype;
			end
			2'h1: begin
				ms_force_master_o  = 1'h0;
				ms_prefer_master_o = cfg_ptype;
			end
			2'h2: begin
				ms_force_master_o  = 1'h0;
				ms_prefer_master_o = 1'h0;
			end
			2'h3: begin
				ms_force_master_o  = 1'h1;
				ms_prefer_master_o = 1'h0;
			end
			default: begin
				ms_force_master_o  = 1'h0;
				ms_prefer_master_o = 1'h0;
			end
		endcase
	end

////////////////////////////////////////////////////////////////////////////////

	// advertisement levels feed the negotiation engine, which picks them up
	// when it next builds its pages
	assign adv_1000_fd_o = st.gig_ctrl[`PGC_GCTL_FD_BIT];
	assign adv_1000_hd_o = st.gig_ctrl[`PGC_GCTL_HD_BIT];

endmodule

//--- sim/pgc_regs_checker.sv
`timescale 1ns/1ns
module pgc_regs_checker(
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic        np_rx_valid_i,
	input wire logic        test_active_o,
	input wire logic        ms_manual_o,
	input wire logic        ms_force_master_o,
	input wire logic        ms_prefer_master_o,
	input wire logic        adv_1000_fd_o,
	input wire logic        adv_1000_hd_o,
	input wire logic [4:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [15:0] np_rx_word_i,
	input wire logic [2:0]  test_mode_o,
	input wire logic [3:0]  test_pair_en_o
);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_n_i);
logic [15:0] wd;
wire w9 = reg_wr_i && reg_addr_i == 5'h09;
always_ff @(posedge sys_clk_i) wd <= reg_wdata_i;
property p_tm; w9 |=> test_mode_o == wd[15:13]; endproperty
a_tm: assert property(p_tm) else $error("mode");
property p_act; {test_active_o,test_pair_en_o} ==
	{5{test_mode_o inside {[1:4]}}}; endproperty
a_act: assert property(p_act) else $error("pairs");
property p_man; w9 |=> ms_manual_o == wd[12]; endproperty
a_man: assert property(p_man) else $error("manual");
property p_frc; w9 |=> ms_force_master_o == (wd[12] & wd[11]); endproperty
a_frc: assert property(p_frc) else $error("force");
property p_prf; w9 |=> ms_prefer_master_o == (!wd[12] & wd[10]); endproperty
a_prf: assert property(p_prf) else $error("prefer");
property p_adv; w9 |=> {adv_1000_fd_o,adv_1000_hd_o} == wd[9:8]; endproperty
a_adv: assert property(p_adv) else $error("adv");
property p_rsv; reg_rd_i && reg_addr_i == 5'h09 |=> reg_rdata_o[7:0] == 8'h00;
endproperty
a_rsv: assert property(p_rsv) else $error("rsvd");
property p_np; reg_rd_i && reg_addr_i == 5'h08 && $past(np_rx_valid_i,2)
	|=> reg_rdata_o == $past(np_rx_word_i,3); endproperty
a_np: assert property(p_np) else $error("page");
c_wr: cover property(w9);
c_tst: cover property(test_pair_en_o == 4'hF);
c_np: cover property(np_rx_valid_i);
endmodule
bind pgc_regs pgc_regs_checker pgc_regs_checker_i(.*);

//--- sim/pgc_link_partner.sv
`timescale 1ns/1ns
module pgc_link_partner(
	input  wire logic        sys_clk_i,
	output logic             np_rx_valid_i = 1'h0,
	output logic      [15:0] np_rx_word_i = 16'h0000
);
// word lines carry the inverse once the page strobe is gone
task send(input logic [15:0] w);
	@(negedge sys_clk_i) {np_rx_valid_i,np_rx_word_i} = {1'b1,w};
	@(negedge sys_clk_i) {np_rx_valid_i,np_rx_word_i} = {1'b0,~w};
endtask
endmodule

//--- sim/test_pgc_regs.sv
`timescale 1ns/1ns
module test_pgc_regs;
logic sys_clk_i = 0,rst_n_i = 0,reg_wr_i = 0,reg_rd_i = 0,np_rx_valid_i;
logic [4:0] reg_addr_i = 0;
logic [15:0] reg_wdata_i = 0,reg_rdata_o,np_rx_word_i;
logic [2:0] test_mode_o;
logic [3:0] test_pair_en_o;
logic test_active_o,ms_manual_o,ms_force_master_o,ms_prefer_master_o;
logic adv_1000_fd_o,adv_1000_hd_o;
int fail_count = 0,num_checks = 0;
wire [12:0] outs = {test_mode_o,test_active_o,test_pair_en_o,ms_manual_o,
	ms_force_master_o,ms_prefer_master_o,adv_1000_fd_o,adv_1000_hd_o};
always #50 sys_clk_i = ~sys_clk_i;
pgc_regs pgc_regs_i(.*);
pgc_link_partner pgc_link_partner_i(.*);
task conclude;
	if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
endtask
task chk(input logic [15:0] s,e);
	num_checks++;
	if (s !== e) begin
		fail_count++;
		$display("ERROR %0t %h %h",$time,s,e);
	end
endtask
task wr(input logic [4:0] a,input logic [15:0] d);
	@(negedge sys_clk_i) {reg_wr_i,reg_addr_i,reg_wdata_i} = {1'b1,a,d};
	@(negedge sys_clk_i) reg_wr_i = 0;
endtask
task rd(input logic [4:0] a,input logic [15:0] e);
	@(negedge sys_clk_i) {reg_rd_i,reg_addr_i} = {1'b1,a};
	@(negedge sys_clk_i) reg_rd_i = 0;
	@(negedge sys_clk_i) chk(reg_rdata_o,e);
endtask
////////////////////////////////////////////////////////////////////////////
task t_mode;
	wr(5'h00,16'h0140);
	for (int m = 0; m < 8; m++) begin
		wr(5'h09,16'(m << 13));
		chk(outs[12:5],{3'(m),{5{m inside {[1:4]}}}});
	end
endtask
task t_ms;
	for (int k = 0; k < 32; k++) begin
		wr(5'h09,16'(k << 8) | 16'h00FF);
		chk({ms_manual_o,ms_force_master_o,ms_prefer_master_o,adv_1000_fd_o,
			adv_1000_hd_o},{k[4],k[4] & k[3],!k[4] & k[2],k[1:0]});
		rd(5'h09,16'(k << 8));
	end
endtask
task t_np;
	pgc_link_partner_i.send(16'hA801);
	rd(5'h08,16'hA801);
	wr(5'h08,16'hFFFF);
	rd(5'h08,16'hA801);
	pgc_link_partner_i.send(16'h57FE);
	rd(5'h08,16'h57FE);
	rd(5'h03,16'h0000);
endtask
task t_reset;
	rd(5'h09,16'h0700);
	rd(5'h08,16'h0000);
	chk(outs,13'h0007);
endtask
task t_rst;
	wr(5'h09,16'hF800);
	chk(outs,13'h1C18);
	pgc_link_partner_i.send(16'h1234);
	@(negedge sys_clk_i) rst_n_i = 0;
	#10 chk(outs,13'h0007);
	@(negedge sys_clk_i) rst_n_i = 1;
	rd(5'h09,16'h0700);
	rd(5'h08,16'h0000);
endtask
initial begin
	repeat (12) @(negedge sys_clk_i);
	rst_n_i = 1;
	t_reset;
	t_mode;
	t_ms;
	t_np;
	t_rst;
	conclude;
end
// run needs about 230 cycles
initial begin
	#200000;
	fail_count++;
	conclude;
end
endmodule
